// file: hdl/cdr_pkg.sv
package cdr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_BOOST       = 8'h03;
  localparam logic [7:0] ADDR_DRIVER_EDGE = 8'h18;
  localparam logic [7:0] ADDR_POLARITY    = 8'h1F;
  localparam logic [7:0] ADDR_ADAPT_TUNE  = 8'h2C;
  localparam logic [7:0] ADDR_RATE_START  = 8'h2F;
  localparam logic [7:0] ADDR_MODE        = 8'h31;
  localparam logic [7:0] ADDR_REFCLK_MODE = 8'h36;
  localparam logic [7:0] ADDR_MONITOR     = 8'h3E;
  localparam logic [7:0] ADDR_EYE_MIN     = 8'h6A;
  localparam logic [7:0] ADDR_WEIGHT      = 8'h6B;
  localparam logic [7:0] ADDR_H_OFFSET    = 8'h6C;
  localparam logic [7:0] ADDR_V_OFFSET    = 8'h6D;
  localparam logic [7:0] ADDR_SCORE_EN    = 8'h6E;
  localparam logic [7:0] ADDR_LOCK_STATUS = 8'h78;

  // ==========================================================
  // Field positions
  localparam int SLOW_EDGE_BIT  = 2;
  localparam int INVERT_BIT     = 7;
  localparam int START_BIT      = 0;
  localparam int RATE_LSB       = 4;
  localparam int SUBRATE_LSB    = 4;
  localparam int SCORE_TYPE_LSB = 3;
  localparam int MODE_LSB       = 5;
  localparam int MONITOR_BIT    = 7;
  localparam int CFG_SCORE_BIT  = 7;
  localparam int LOCKED_BIT     = 0;
  localparam int LOL_BIT        = 1;
  localparam int LOL_ACK_BIT    = 0;

  // ==========================================================
  // Codes
  localparam logic [1:0] MODE_NONE       = 2'h0;
  localparam logic [1:0] MODE_ADAPT      = 2'h1;
  localparam logic [1:0] SCORE_COMBINED  = 2'h0;
  localparam logic [1:0] SCORE_HORIZ     = 2'h1;
  localparam logic [1:0] SCORE_VERT      = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BOOST   = 8'h00;
  localparam logic [7:0] RST_EDGE    = 8'h00;
  localparam logic [7:0] RST_POL     = 8'h00;
  localparam logic [7:0] RST_TUNE    = 8'h02;
  localparam logic [7:0] RST_RATE    = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h20;
  localparam logic [7:0] RST_REFMODE = 8'h00;
  localparam logic [7:0] RST_MONITOR = 8'h80;
  localparam logic [7:0] RST_EYE_MIN = 8'h44;
  localparam logic [7:0] RST_WEIGHT  = 8'h80;
  localparam logic [7:0] RST_H_OFF   = 8'h00;
  localparam logic [7:0] RST_V_OFF   = 8'h00;
  localparam logic [7:0] RST_SCORE   = 8'h00;

  // ==========================================================
  // Timing and scaling
  localparam int CLK_PERIOD_NS      = 40;
  localparam int FREQ_WINDOW_NS     = 10000;
  localparam int FREQ_WINDOW_CYCLES = FREQ_WINDOW_NS / CLK_PERIOD_NS;
  localparam int WIN_W              = $clog2(FREQ_WINDOW_CYCLES);
  localparam logic [7:0] VEO_SCALE  = 8'h80;
  localparam int VEO_SCALE_SHIFT    = 7;
  localparam logic [9:0] WEIGHT_ONE = 10'h100;

  // ==========================================================
  // Candidate boost settings
  localparam int CAND_N = 16;
  localparam logic [7:0] BOOST_TABLE [CAND_N] = '{
    8'h00, 8'h01, 8'h04, 8'h10, 8'h40, 8'h08, 8'h02, 8'h80,
    8'h03, 8'h0C, 8'h30, 8'h41, 8'h50, 8'hC0, 8'h60, 8'h90};

  // ==========================================================
  // Types
  typedef struct packed {
    logic       valid;
    logic [7:0] horizontal_eye_opening;
    logic [7:0] vertical_eye_opening;
  } eye_meas_type;

  typedef enum logic [2:0] {
    ST_CAL, ST_ACQUIRE, ST_LOAD, ST_APPLY, ST_MEAS, ST_QUALIFY, ST_LOCKED
  } lock_state_type;

  typedef struct packed {
    lock_state_type state;
    logic [7:0]     boost;
    logic [7:0]     edge_ctl;
    logic [7:0]     pol_ctl;
    logic [7:0]     tune;
    logic [7:0]     rate;
    logic [7:0]     mode;
    logic [7:0]     refmode;
    logic [7:0]     monitor;
    logic [7:0]     eye_min;
    logic [7:0]     weight;
    logic [7:0]     h_off;
    logic [7:0]     v_off;
    logic [7:0]     score_en;
    logic [3:0]     cand_idx;
    logic [3:0]     best_idx;
    logic [7:0]     best_score;
    logic [3:0]     beyond;
    logic [3:0]     tab_addr;
    logic           restoring;
    logic [2:0]     coarse;
    logic [WIN_W-1:0] win_cnt;
    logic [9:0]     tick_cnt;
    logic           locked;
    logic           lol;
    logic [7:0]     rdata;
  } ctrl_state_type;

endpackage : cdr_pkg

// file: hdl/boost_table.sv
`timescale 1ns/100ps
`default_nettype none

module boost_table
  import cdr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = CAND_N
)
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  output var  logic [WIDTH-1:0]         rdata
);

  // ==========================================================
  // Registered read of candidate settings
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= WIDTH'(BOOST_TABLE[addr]);
    end
  end

endmodule : boost_table

`default_nettype wire

// file: hdl/cdr_adaptation_lock_control.sv
`timescale 1ns/100ps
`default_nettype none

module cdr_adaptation_lock_control
  import cdr_pkg::*;
#(
  parameter logic [9:0] TARGET_TICKS = 10'd200,
  parameter logic [9:0] FREQ_TOL     = 10'd4
)
(
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  input  wire eye_meas_type eye_meas,
  input  wire logic         phase_locked,
  input  wire logic         osc_div_tick,
  output logic              slow_edge,
  output logic              invert_polarity,
  output logic      [3:0]   rate_search_code,
  output logic      [7:0]   eq_boost,
  output logic      [2:0]   coarse_tune,
  output logic              cdr_locked,
  output logic              loss_of_lock_irq
);

  // ==========================================================
  // Functions
  function automatic logic [7:0] eye_score(
    input eye_meas_type m,
    input logic [1:0]   kind,
    input logic         cfg_en,
    input logic [7:0]   a,
    input logic [7:0]   b,
    input logic [7:0]   c
  );
    logic [15:0]        vprod;
    logic [7:0]         vscaled;
    logic signed [9:0]  dh;
    logic signed [9:0]  dv;
    logic signed [9:0]  wa;
    logic signed [9:0]  wb;
    logic signed [20:0] acc;
    logic [7:0]         res;
    vprod   = 16'(m.vertical_eye_opening * VEO_SCALE);
    vprod   = vprod >> VEO_SCALE_SHIFT;
    vscaled = (vprod > 16'h00FF) ? 8'hFF : vprod[7:0];
    dh      = $signed({2'b00, m.horizontal_eye_opening}) - $signed({2'b00, b});
    dv      = $signed({2'b00, m.vertical_eye_opening}) - $signed({2'b00, c});
    wa      = $signed({2'b00, a});
    wb      = $signed(WEIGHT_ONE - {2'b00, a});
    acc     = 21'(dh * wa) + 21'(dv * wb);
    acc     = acc >>> 8;
    if (cfg_en)
    begin
      if (acc < 0)
        res = 8'h00;
      else if (acc > 21'sd255)
        res = 8'hFF;
      else
        res = acc[7:0];
    end
    else if (kind == SCORE_HORIZ)
      res = m.horizontal_eye_opening;
    else if (kind == SCORE_VERT)
      res = m.vertical_eye_opening;
    else
      res = (m.horizontal_eye_opening < vscaled) ? m.horizontal_eye_opening : vscaled;
    return res;
  endfunction : eye_score

  function automatic logic eye_open_ok(
    input eye_meas_type m,
    input logic [7:0]   mins
  );
    return (m.horizontal_eye_opening > {mins[7:4], 4'h0}) && (m.vertical_eye_opening > {mins[3:0], 4'h0});
  endfunction : eye_open_ok

  // ==========================================================
  // State
  ctrl_state_type s_r;
  ctrl_state_type s_nxt;
  logic [7:0]     tab_rdata;

  boost_table #(
    .WIDTH (8),
    .DEPTH (CAND_N)
  ) u_table (
    .clock (clock),
    .nrst  (nrst),
    .addr  (s_r.tab_addr),
    .rdata (tab_rdata)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [9:0] ticks;
    logic [9:0] expect_ticks;
    logic [9:0] diff;
    logic       win_end;
    logic       freq_err;
    logic       start_req;
    logic       adapt_on;
    logic       improved;
    logic [7:0] score;
    ticks        = s_r.tick_cnt + {9'h000, osc_div_tick};
    expect_ticks = TARGET_TICKS >> s_r.rate[SUBRATE_LSB +: 2];
    diff         = (ticks > expect_ticks) ? ticks - expect_ticks : expect_ticks - ticks;
    win_end      = (s_r.win_cnt == WIN_W'(FREQ_WINDOW_CYCLES - 1));
    freq_err     = win_end && (diff > FREQ_TOL);
    start_req    = 1'b0;
    adapt_on     = (s_r.mode[MODE_LSB +: 2] == MODE_ADAPT);
    improved     = 1'b0;
    score        = eye_score(eye_meas, s_r.mode[SCORE_TYPE_LSB +: 2],
                             s_r.score_en[CFG_SCORE_BIT],
                             s_r.weight, s_r.h_off, s_r.v_off);
    s_nxt = s_r;

    // Reference frequency window
    if (win_end)
    begin
      s_nxt.win_cnt  = '0;
      s_nxt.tick_cnt = '0;
    end
    else
    begin
      s_nxt.win_cnt  = s_r.win_cnt + WIN_W'(1);
      s_nxt.tick_cnt = ticks;
    end

    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == ADDR_BOOST)
        s_nxt.boost = reg_wdata;
      else if (reg_addr == ADDR_DRIVER_EDGE)
        s_nxt.edge_ctl = reg_wdata;
      else if (reg_addr == ADDR_POLARITY)
        s_nxt.pol_ctl = reg_wdata;
      else if (reg_addr == ADDR_ADAPT_TUNE)
        s_nxt.tune = reg_wdata;
      else if (reg_addr == ADDR_RATE_START)
      begin
        s_nxt.rate = reg_wdata;
        start_req  = s_r.rate[START_BIT] && !reg_wdata[START_BIT];
      end
      else if (reg_addr == ADDR_MODE)
        s_nxt.mode = reg_wdata;
      else if (reg_addr == ADDR_REFCLK_MODE)
        s_nxt.refmode = reg_wdata;
      else if (reg_addr == ADDR_MONITOR)
        s_nxt.monitor = reg_wdata;
      else if (reg_addr == ADDR_EYE_MIN)
        s_nxt.eye_min = reg_wdata;
      else if (reg_addr == ADDR_WEIGHT)
        s_nxt.weight = reg_wdata;
      else if (reg_addr == ADDR_H_OFFSET)
        s_nxt.h_off = reg_wdata;
      else if (reg_addr == ADDR_V_OFFSET)
        s_nxt.v_off = reg_wdata;
      else if (reg_addr == ADDR_SCORE_EN)
        s_nxt.score_en = reg_wdata;
      else if (reg_addr == ADDR_LOCK_STATUS && reg_wdata[LOL_ACK_BIT])
        s_nxt.lol = 1'b0;
    end

    // Register reads
    if (reg_rd)
    begin
      if (reg_addr == ADDR_BOOST)
        s_nxt.rdata = s_r.boost;
      else if (reg_addr == ADDR_DRIVER_EDGE)
        s_nxt.rdata = s_r.edge_ctl;
      else if (reg_addr == ADDR_POLARITY)
        s_nxt.rdata = s_r.pol_ctl;
      else if (reg_addr == ADDR_ADAPT_TUNE)
        s_nxt.rdata = s_r.tune;
      else if (reg_addr == ADDR_RATE_START)
        s_nxt.rdata = s_r.rate;
      else if (reg_addr == ADDR_MODE)
        s_nxt.rdata = s_r.mode;
      else if (reg_addr == ADDR_REFCLK_MODE)
        s_nxt.rdata = s_r.refmode;
      else if (reg_addr == ADDR_MONITOR)
        s_nxt.rdata = s_r.monitor;
      else if (reg_addr == ADDR_EYE_MIN)
        s_nxt.rdata = s_r.eye_min;
      else if (reg_addr == ADDR_WEIGHT)
        s_nxt.rdata = s_r.weight;
      else if (reg_addr == ADDR_H_OFFSET)
        s_nxt.rdata = s_r.h_off;
      else if (reg_addr == ADDR_V_OFFSET)
        s_nxt.rdata = s_r.v_off;
      else if (reg_addr == ADDR_SCORE_EN)
        s_nxt.rdata = s_r.score_en;
      else if (reg_addr == ADDR_LOCK_STATUS)
        s_nxt.rdata = {3'h0, s_r.coarse, s_r.lol, s_r.locked};
      else
        s_nxt.rdata = 8'h00;
    end

    // Lock and adaptation sequence
    case (s_r.state)
      ST_CAL:
      begin
        if (win_end)
        begin
          if (ticks >= expect_ticks || s_r.coarse == 3'h7)
            s_nxt.state = ST_ACQUIRE;
          else
            s_nxt.coarse = s_r.coarse + 3'h1;
        end
      end
      ST_ACQUIRE:
      begin
        if (freq_err)
          s_nxt.state = ST_ACQUIRE;
        else if (phase_locked)
        begin
          if (adapt_on)
          begin
            s_nxt.state      = ST_LOAD;
            s_nxt.cand_idx   = 4'h0;
            s_nxt.tab_addr   = 4'h0;
            s_nxt.best_idx   = 4'h0;
            s_nxt.best_score = 8'h00;
            s_nxt.beyond     = 4'h0;
            s_nxt.restoring  = 1'b0;
          end
          else
            s_nxt.state = ST_QUALIFY;
        end
      end
      ST_LOAD:
        s_nxt.state = ST_APPLY;
      ST_APPLY:
      begin
        s_nxt.boost = tab_rdata;
        if (s_r.restoring)
          s_nxt.state = ST_QUALIFY;
        else
          s_nxt.state = ST_MEAS;
      end
      ST_MEAS:
      begin
        if (freq_err)
          s_nxt.state = ST_ACQUIRE;
        else if (eye_meas.valid && phase_locked)
        begin
          improved = (score > s_r.best_score) || (s_r.cand_idx == 4'h0);
          if (improved)
          begin
            s_nxt.best_score = score;
            s_nxt.best_idx   = s_r.cand_idx;
            s_nxt.beyond     = 4'h0;
          end
          else
            s_nxt.beyond = s_r.beyond + 4'h1;
          if ((!improved && s_r.beyond + 4'h1 > s_r.tune[3:0])
              || s_r.cand_idx == 4'(CAND_N - 1))
          begin
            s_nxt.restoring = 1'b1;
            s_nxt.tab_addr  = improved ? s_r.cand_idx : s_r.best_idx;
            s_nxt.state     = ST_LOAD;
          end
          else
          begin
            s_nxt.cand_idx = s_r.cand_idx + 4'h1;
            s_nxt.tab_addr = s_r.cand_idx + 4'h1;
            s_nxt.state    = ST_LOAD;
          end
        end
      end
      ST_QUALIFY:
      begin
        if (freq_err)
          s_nxt.state = ST_ACQUIRE;
        else if (eye_meas.valid)
        begin
          if (eye_open_ok(eye_meas, s_r.eye_min) && phase_locked)
          begin
            s_nxt.state  = ST_LOCKED;
            s_nxt.locked = 1'b1;
          end
          else
            s_nxt.state = ST_ACQUIRE;
        end
      end
      ST_LOCKED:
      begin
        if (freq_err || !phase_locked
            || (s_r.monitor[MONITOR_BIT] && eye_meas.valid
                && !eye_open_ok(eye_meas, s_r.eye_min)))
        begin
          s_nxt.state  = ST_ACQUIRE;
          s_nxt.locked = 1'b0;
          s_nxt.lol    = 1'b1;
        end
      end
      default:
        s_nxt.state = ST_ACQUIRE;
    endcase

    // Host start overrides any running sequence except coarse calibration (ST_CAL)
    if (start_req && s_r.state != ST_CAL)
    begin
      s_nxt.state  = ST_ACQUIRE;
      s_nxt.locked = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r            <= '0;
      s_r.state      <= ST_CAL;
      s_r.boost      <= RST_BOOST;
      s_r.edge_ctl   <= RST_EDGE;
      s_r.pol_ctl    <= RST_POL;
      s_r.tune       <= RST_TUNE;
      s_r.rate       <= RST_RATE;
      s_r.mode       <= RST_MODE;
      s_r.refmode    <= RST_REFMODE;
      s_r.monitor    <= RST_MONITOR;
      s_r.eye_min    <= RST_EYE_MIN;
      s_r.weight     <= RST_WEIGHT;
      s_r.h_off      <= RST_H_OFF;
      s_r.v_off      <= RST_V_OFF;
      s_r.score_en   <= RST_SCORE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata        = s_r.rdata;
  assign slow_edge        = s_r.edge_ctl[SLOW_EDGE_BIT];
  assign invert_polarity  = s_r.pol_ctl[INVERT_BIT];
  assign rate_search_code = s_r.rate[RATE_LSB +: 4];
  assign eq_boost         = s_r.boost;
  assign coarse_tune      = s_r.coarse;
  assign cdr_locked       = s_r.locked;
  assign loss_of_lock_irq = s_r.lol;

endmodule : cdr_adaptation_lock_control

`default_nettype wire

// file: test/cdr_chk.sv
`timescale 1ns/100ps
`default_nettype none

module cdr_chk
  import cdr_pkg::*;
(
  input wire logic         clock,
  input wire logic         nrst,
  input wire logic [7:0]   reg_addr,
  input wire logic [7:0]   reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [7:0]   reg_rdata,
  input wire eye_meas_type eye_meas,
  input wire logic         phase_locked,
  input wire logic         osc_div_tick,
  input wire logic         slow_edge,
  input wire logic         invert_polarity,
  input wire logic [3:0]   rate_search_code,
  input wire logic [7:0]   eq_boost,
  input wire logic [2:0]   coarse_tune,
  input wire logic         cdr_locked,
  input wire logic         loss_of_lock_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Properties
  a_slow_edge_write: assert property (
    reg_wr && reg_addr == ADDR_DRIVER_EDGE |=> slow_edge == $past(reg_wdata[SLOW_EDGE_BIT]))
    else $error("slow_edge does not follow its write");
  a_polarity_write: assert property (
    reg_wr && reg_addr == ADDR_POLARITY |=> invert_polarity == $past(reg_wdata[INVERT_BIT]))
    else $error("invert_polarity does not follow its write");
  a_rate_code_write: assert property (
    reg_wr && reg_addr == ADDR_RATE_START |=> rate_search_code == $past(reg_wdata[7:4]))
    else $error("rate_search_code does not follow its write");
  a_lock_needs_eye: assert property (
    $rose(cdr_locked) |-> $past(eye_meas.valid && phase_locked))
    else $error("lock declared without a qualifying eye result");
  a_phase_loss_irq: assert property (
    cdr_locked && !phase_locked |=> !cdr_locked && loss_of_lock_irq)
    else $error("phase loss in lock not reported next cycle");
  a_irq_from_lock: assert property (
    $rose(loss_of_lock_irq) |-> $past(cdr_locked))
    else $error("loss of lock raised while not locked");
  a_irq_sticky: assert property (
    loss_of_lock_irq && !(reg_wr && reg_addr == ADDR_LOCK_STATUS && reg_wdata[LOL_ACK_BIT])
    |=> loss_of_lock_irq)
    else $error("loss of lock dropped without acknowledge");
  a_coarse_hold: assert property (
    cdr_locked |-> $stable(coarse_tune))
    else $error("coarse tuning moved while locked");
  a_boost_read: assert property (
    reg_rd && !reg_wr && reg_addr == ADDR_BOOST |=> reg_rdata == $past(eq_boost))
    else $error("boost register read differs from eq_boost");
endmodule : cdr_chk

bind cdr_adaptation_lock_control cdr_chk chk (
  .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eye_meas(eye_meas),
  .phase_locked(phase_locked), .osc_div_tick(osc_div_tick), .slow_edge(slow_edge),
  .invert_polarity(invert_polarity), .rate_search_code(rate_search_code),
  .eq_boost(eq_boost), .coarse_tune(coarse_tune), .cdr_locked(cdr_locked),
  .loss_of_lock_irq(loss_of_lock_irq));

`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_model
  import cdr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  // ==========================================================
  // Register cycles
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clock);
    d = reg_rdata;
  endtask : rd

  task setup();
    wr(8'hFF, 8'h01);
    wr(ADDR_REFCLK_MODE, 8'h30);
  endtask : setup

  task start(input logic [7:0] r);
    wr(ADDR_RATE_START, r | 8'h01);
    wr(ADDR_RATE_START, r & 8'hFE);
  endtask : start
endmodule : host_model

`default_nettype wire

// file: test/cdr_adaptation_lock_control_test.sv
`timescale 1ns/100ps
`default_nettype none

module cdr_adaptation_lock_control_test
  import cdr_pkg::*;
();
  logic         clock = 1'b0;
  logic         nrst = 1'b0;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, eq_boost, d, lastb;
  logic         reg_wr, reg_rd, slow_edge, invert_polarity, cdr_locked, loss_of_lock_irq;
  logic         phase_locked = 1'b0;
  logic         osc_div_tick = 1'b0;
  logic [3:0]   rate_search_code;
  logic [2:0]   coarse_tune;
  eye_meas_type eye_meas = '0;
  logic [7:0]   eh [16], ev [16];
  int           err_count = 0, checks = 0, cyc = 0, acc = 0, drift = 0, scnt = 0;
  int           lb, a, b, c, e;
  localparam logic [7:0] RA [13] = '{ADDR_BOOST, ADDR_DRIVER_EDGE, ADDR_POLARITY,
    ADDR_ADAPT_TUNE, ADDR_RATE_START, ADDR_MODE, ADDR_REFCLK_MODE, ADDR_MONITOR,
    ADDR_EYE_MIN, ADDR_WEIGHT, ADDR_H_OFFSET, ADDR_V_OFFSET, ADDR_SCORE_EN};
  localparam logic [7:0] RV [13] = '{RST_BOOST, RST_EDGE, RST_POL, RST_TUNE, RST_RATE,
    RST_MODE, RST_REFMODE, RST_MONITOR, RST_EYE_MIN, RST_WEIGHT, RST_H_OFF, RST_V_OFF,
    RST_SCORE};

  cdr_adaptation_lock_control uut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .eye_meas(eye_meas), .phase_locked(phase_locked), .osc_div_tick(osc_div_tick),
    .slow_edge(slow_edge), .invert_polarity(invert_polarity),
    .rate_search_code(rate_search_code), .eq_boost(eq_boost), .coarse_tune(coarse_tune),
    .cdr_locked(cdr_locked), .loss_of_lock_irq(loss_of_lock_irq));
  host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // ==========================================================
  // Clock, oscillator and eye monitor
  always #20 clock = ~clock;

  always @(posedge clock)
  begin
    acc = acc + 141 + 20 * coarse_tune + drift;
    osc_div_tick <= (acc >= 250);
    if (acc >= 250)
      acc = acc - 250;
    scnt = (eq_boost !== lastb) ? 0 : scnt + 1;
    lastb = eq_boost;
    cyc++;
    eye_meas <= '{scnt > 4 && cyc % 16 == 0, eh[idx(eq_boost)], ev[idx(eq_boost)]};
    if (cyc > 30000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // Expectations and checks
  function automatic int idx(logic [7:0] v);
    for (int i = 0; i < CAND_N; i++)
      if (BOOST_TABLE[i] === v)
        return i;
    return 0;
  endfunction : idx

  function automatic int sc(int i, int k);
    int s;
    s = (k == 3) ? (a * (eh[i] - b) + (256 - a) * (ev[i] - c)) / 256
      : (k == 1) ? eh[i] : (k == 2) ? ev[i] : (eh[i] < ev[i] ? eh[i] : ev[i]);
    return s > 255 ? 255 : s;
  endfunction : sc

  function automatic int win(int k);
    int best, n;
    best = 0;
    n = 0;
    for (int i = 1; i < CAND_N && n <= lb; i++)
      if (sc(i, k) > sc(best, k))
      begin
        best = i;
        n = 0;
      end
      else
        n++;
    return best;
  endfunction : win

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task waitc(input int sel, input int n);
    while (n > 0 && !(sel == 0 ? cdr_locked === 1'b1
        : sel == 1 ? loss_of_lock_irq === 1'b1 : cdr_locked === 1'b0))
    begin
      @(negedge clock);
      n--;
    end
  endtask : waitc

  task fill(input logic [7:0] h, input logic [7:0] v);
    @(negedge clock);
    for (int i = 0; i < CAND_N; i++)
    begin
      eh[i] = h;
      ev[i] = v;
    end
  endtask : fill

  task ack();
    host.wr(ADDR_LOCK_STATUS, 8'h01);
  endtask : ack

  task print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Main sequence
  initial
  begin
    d = 8'($urandom(32'h6D1B));
    fill(8'h40, 8'h60);
    repeat (4) @(posedge clock);
    check("rst_out", {2'h0, slow_edge, invert_polarity, rate_search_code}, 8'h00);
    check("rst_lock", {5'h0, coarse_tune}, {6'h0, cdr_locked, loss_of_lock_irq});
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 13; i++)
    begin
      host.rd(RA[i], d);
      check("rst_reg", d, RV[i]);
    end
    host.rd(8'h55, d);
    check("unmapped", d, 8'h00);
    repeat (1400) @(negedge clock);
    check("coarse", {5'h0, coarse_tune}, 8'h03);
    for (int i = 0; i < 7; i++)
    begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      host.wr(ADDR_DRIVER_EDGE, d);
      host.wr(ADDR_POLARITY, d);
      host.wr(ADDR_RATE_START, d & 8'hF0);
      @(negedge clock);
      check("slow_edge", {7'h0, slow_edge}, {7'h0, d[2]});
      check("invert", {7'h0, invert_polarity}, {7'h0, d[7]});
      check("rate", {4'h0, rate_search_code}, {4'h0, d[7:4]});
    end
    host.setup();
    host.wr(ADDR_MODE, 8'h00);
    @(posedge clock);
    phase_locked <= 1'b1;
    host.start(8'h00);
    repeat (100) @(negedge clock);
    check("no_lock", {7'h0, cdr_locked}, 8'h00);
    fill(8'h41, 8'h41);
    waitc(0, 200);
    check("lock", {7'h0, cdr_locked}, 8'h01);
    check("boost_kept", eq_boost, RST_BOOST);
    fill(8'h60, 8'h3F);
    waitc(1, 100);
    check("eye_loss", {6'h0, cdr_locked, loss_of_lock_irq}, 8'h01);
    fill(8'h50, 8'h50);
    waitc(0, 300);
    check("relock", {6'h0, cdr_locked, loss_of_lock_irq}, 8'h03);
    ack();
    host.rd(ADDR_LOCK_STATUS, d);
    check("status", d, 8'h0D);
    host.wr(ADDR_MONITOR, 8'h00);
    fill(8'h20, 8'h20);
    repeat (100) @(negedge clock);
    check("no_monitor", {7'h0, cdr_locked}, 8'h01);
    fill(8'h50, 8'h50);
    host.wr(ADDR_MONITOR, RST_MONITOR);
    drift = 20;
    waitc(1, 600);
    check("drift_loss", {6'h0, cdr_locked, loss_of_lock_irq}, 8'h01);
    drift = 0;
    ack();
    waitc(0, 1500);
    check("drift_relock", {7'h0, cdr_locked}, 8'h01);
    @(posedge clock);
    phase_locked <= 1'b0;
    @(posedge clock);
    phase_locked <= 1'b1;
    @(negedge clock);
    check("phase_loss", {7'h0, loss_of_lock_irq}, 8'h01);
    ack();
    waitc(0, 300);
    for (int k = 0; k < 4; k++)
    begin
      lb = $urandom % 4;
      a = $urandom % 256;
      b = $urandom % 32;
      c = $urandom % 32;
      @(negedge clock);
      for (int i = 0; i < CAND_N; i++)
      begin
        eh[i] = 8'h48 + 8'($urandom % 128);
        ev[i] = 8'h48 + 8'($urandom % 128);
      end
      host.wr(ADDR_ADAPT_TUNE, 8'(lb));
      host.wr(ADDR_MODE, 8'h20 | 8'((k % 3) << SCORE_TYPE_LSB));
      host.wr(ADDR_SCORE_EN, k == 3 ? 8'h80 : 8'h00);
      host.wr(ADDR_WEIGHT, 8'(a));
      host.wr(ADDR_H_OFFSET, 8'(b));
      host.wr(ADDR_V_OFFSET, 8'(c));
      // Keep the eye strobe clear of the first boost change
      while (cyc % 16 != 0)
        @(negedge clock);
      host.start(8'h00);
      waitc(2, 20);
      waitc(0, 3000);
      e = win(k);
      check("boost", eq_boost, BOOST_TABLE[e]);
      host.rd(ADDR_BOOST, d);
      check("boost_reg", d, BOOST_TABLE[e]);
    end
    print_verdict();
  end
endmodule : cdr_adaptation_lock_control_test

`default_nettype wire
